// *** hw/dmaag_defines.vh ***
// Constants for the DMA channel address generator
//
// Summary of operation
// RULE_01: A channel's block-complete event sets its own interrupt status flag.
// RULE_02: Software clears a channel flag in its service routine, else it repeats.
// RULE_03: Flags sit at status reg 0 bits 4 and 14, status reg 1 bit 8.
// RULE_04: Post-increment mode advances the RAM address after each element.
// RULE_05: Mode field value 00 selects post-increment register-indirect addressing.
// RULE_06: After reset every channel's mode is post-increment.
// RULE_07: Post-increment start address comes from the active buffer's start offset.
// RULE_08: Reading a start offset returns the latest RAM offset used.
// RULE_09: The programmed start offset is changed only by software writes.
// RULE_10: No-increment mode leaves the RAM address unchanged after each transfer.
// RULE_11: Mode field value 01 selects register-indirect without increment.
// RULE_12: Switching to no-increment mid-block keeps the running address.
// RULE_13: Increment is 2 for word elements and 1 for byte elements.
// RULE_14: Mode field with upper bit set uses peripheral-supplied low bits.
// RULE_15: A block completes after count plus one requests; zero moves one.
// RULE_16: Each block start reloads the start offset, added to RAM base.
`ifndef DMAAG_DEFINES_VH
`define DMAAG_DEFINES_VH

`define DMAAG_NCH         3
`define DMAAG_OFS_W       11
`define DMAAG_CNT_W       10
`define DMAAG_RAM_BASE    16'h4000

// Register address bit fields, register indices and byte offsets
`define DMAAG_CH_SEL_HI   7
`define DMAAG_CH_SEL_LO   6
`define DMAAG_CH_IDX_HI   5
`define DMAAG_CH_IDX_LO   4
`define DMAAG_REG_HI      3
`define DMAAG_REG_LO      2
`define DMAAG_ALIGN_HI    1
`define DMAAG_ALIGN_LO    0
`define DMAAG_R_CTRL      2'h0
`define DMAAG_R_STA       2'h1
`define DMAAG_R_STB       2'h2
`define DMAAG_R_CNT       2'h3
`define DMAAG_A_FLAG0     8'h40
`define DMAAG_A_FLAG1     8'h44
`define DMAAG_A_MASK0     8'h48
`define DMAAG_A_MASK1     8'h4c

// Control register fields
`define DMAAG_C_BUFSEL    0
`define DMAAG_C_MODE_HI   5
`define DMAAG_C_MODE_LO   4
`define DMAAG_C_DIR       13
`define DMAAG_C_SIZE      14
`define DMAAG_C_EN        15
`define DMAAG_CTRL_RST    16'h0000
`define DMAAG_CTRL_MSK    16'he031

// Addressing modes
`define DMAAG_M_POSTINC   2'h0
`define DMAAG_M_NOINC     2'h1

// Flag positions
`define DMAAG_F_CH0       4
`define DMAAG_F_CH1       14
`define DMAAG_F_CH2       8
`define DMAAG_FLAG0_MSK   16'h4010
`define DMAAG_FLAG1_MSK   16'h0100

`define DMAAG_STEP_WORD   11'h002
`define DMAAG_STEP_BYTE   11'h001

`endif

// *** hw/dmaag_sync.v ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module dmaag_sync #(
    parameter W = 3
) (
    input  wire         mclk,
    input  wire         reset,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;
    genvar i;

    always @(posedge mclk) begin
        if (reset) begin
            s1 <= {W{1'b0}};
            s2 <= {W{1'b0}};
            s3 <= {W{1'b0}};
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Only take a new level once stages two and three agree
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge mclk) begin
                if (reset) begin
                    sync_out[i] <= 1'b0;
                end else if (s2[i] == s3[i]) begin
                    sync_out[i] <= s3[i];
                end
            end
        end
    endgenerate
endmodule // dmaag_sync

// *** hw/dmaag_channel.v ***
// DMA address generation for three channels with APB registers
`timescale 1ns/100ps
`include "dmaag_defines.vh"
module dmaag_channel (
    input  wire        mclk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [2:0]  periph_req,
    input  wire [32:0] periph_addr,
    output reg  [15:0] ram_addr,
    output reg         ram_strobe,
    output reg         ram_write,
    output reg         ram_byte,
    output reg  [1:0]  ram_channel,
    output reg         irq
);
    wire [2:0]  req_lvl;
    reg  [2:0]  req_prev;
    wire [2:0]  req_rise;
    wire [2:0]  pend;
    wire [3:0]  lower;
    wire [2:0]  grant;
    wire [2:0]  blk_done;
    wire [32:0] use_ofs;
    wire [2:0]  ch_byte;
    wire [2:0]  ch_dir;
    wire [95:0] ch_rdata;
    wire        setup;
    wire        wr_en;
    wire        ch_space;
    wire [1:0]  ch_idx;
    wire [1:0]  reg_idx;
    wire        ch_valid;
    wire        aligned;
    wire        flag0_wr;
    wire        flag1_wr;
    wire        mask0_wr;
    wire        mask1_wr;
    reg  [15:0] flag0;
    reg  [15:0] flag1;
    reg  [15:0] mask0;
    reg  [15:0] mask1;
    reg  [15:0] next_flag0;
    reg  [15:0] next_flag1;
    reg  [31:0] next_rdata;
    reg         next_err;
    reg  [10:0] sel_ofs;
    genvar i;

    // Only the request pins are synchronised; periph_addr must hold
    // steady from its request edge until the strobe that uses it
    dmaag_sync #(
        .W (3)
    ) u_req_sync (
        .mclk     (mclk),
        .reset    (reset),
        .async_in (periph_req),
        .sync_out (req_lvl)
    );

    always @(posedge mclk) begin
        if (reset) begin
            req_prev <= 3'h0;
        end else begin
            req_prev <= req_lvl;
        end
    end

    assign req_rise = req_lvl & ~req_prev;

    // Map: channel n at 0x10*n holds control, start A, start B, count;
    // flags and masks sit above the channel space
    // APB decode; no wait state, read data comes from a flip-flop loaded in setup
    assign setup    = psel & ~penable;
    assign wr_en    = psel & penable & pready & pwrite & ~pslverr;
    assign aligned  = (paddr[`DMAAG_ALIGN_HI:`DMAAG_ALIGN_LO] == 2'h0);
    assign ch_space = (paddr[`DMAAG_CH_SEL_HI:`DMAAG_CH_SEL_LO] == 2'h0);
    assign ch_idx   = paddr[`DMAAG_CH_IDX_HI:`DMAAG_CH_IDX_LO];
    assign reg_idx  = paddr[`DMAAG_REG_HI:`DMAAG_REG_LO];
    assign ch_valid = ch_space & (ch_idx != 2'h3) & aligned;

    // Write strobes for the shared flag and mask words
    assign flag0_wr = wr_en & (paddr == `DMAAG_A_FLAG0);
    assign flag1_wr = wr_en & (paddr == `DMAAG_A_FLAG1);
    assign mask0_wr = wr_en & (paddr == `DMAAG_A_MASK0);
    assign mask1_wr = wr_en & (paddr == `DMAAG_A_MASK1);

    // Fixed priority: lowest channel number wins
    assign lower[0] = 1'b0;

    generate
        for (i = 0; i < `DMAAG_NCH; i = i + 1) begin : g_ch
            reg  [15:0] ctrl;
            reg  [10:0] sta;
            reg  [10:0] stb;
            reg  [9:0]  cnt;
            reg  [10:0] show_a;
            reg  [10:0] show_b;
            reg  [10:0] run_addr;
            reg  [9:0]  served;
            reg         active;
            reg         pend_r;
            reg  [10:0] ofs_now;
            reg  [10:0] next_run;
            reg  [15:0] rd;
            wire [1:0]  mode;
            wire        en;
            wire        use_b;
            wire [10:0] start;
            wire [10:0] pia;
            wire        hit;
            wire        last;
            // Slice number sized like the channel index field
            localparam [1:0] CH_ID = i;

            assign mode  = ctrl[`DMAAG_C_MODE_HI:`DMAAG_C_MODE_LO];
            assign en    = ctrl[`DMAAG_C_EN];
            assign use_b = ctrl[`DMAAG_C_BUFSEL];
            assign start = use_b ? stb : sta; // RULE_07
            assign pia   = periph_addr[i*11 +: 11];
            assign hit   = wr_en & ch_valid & (ch_idx == CH_ID);
            assign last  = (served == cnt); // RULE_15

            assign pend[i]     = pend_r;
            assign lower[i+1]  = lower[i] | pend[i];
            assign grant[i]    = pend[i] & ~lower[i];
            assign blk_done[i] = grant[i] & last;
            assign use_ofs[i*11 +: 11] = ofs_now;
            assign ch_byte[i]  = ctrl[`DMAAG_C_SIZE];
            assign ch_dir[i]   = ctrl[`DMAAG_C_DIR];
            assign ch_rdata[i*32 +: 32] = {16'h0000, rd};

            always @* begin
                if (mode[1]) begin
                    ofs_now = start | pia; // RULE_14
                end else if (active) begin
                    ofs_now = run_addr; // RULE_12
                end else begin
                    ofs_now = start; // RULE_16
                end
                case (mode)
                    `DMAAG_M_POSTINC: begin // RULE_05
                        if (ctrl[`DMAAG_C_SIZE]) begin
                            next_run = ofs_now + `DMAAG_STEP_BYTE; // RULE_13
                        end else begin
                            next_run = ofs_now + `DMAAG_STEP_WORD; // RULE_13
                        end
                    end
                    `DMAAG_M_NOINC: next_run = ofs_now; // RULE_10 RULE_11
                    default: next_run = run_addr;
                endcase
                case (reg_idx)
                    `DMAAG_R_CTRL: rd = ctrl;
                    `DMAAG_R_STA:  rd = {5'h00, show_a}; // RULE_08
                    `DMAAG_R_STB:  rd = {5'h00, show_b}; // RULE_08
                    default:       rd = {6'h00, cnt};
                endcase
            end

            // Software writes; programmed offsets never touched by transfers
            always @(posedge mclk) begin
                if (reset) begin
                    ctrl <= `DMAAG_CTRL_RST; // RULE_06
                    sta  <= 11'h000;
                    stb  <= 11'h000;
                    cnt  <= 10'h000;
                end else if (hit) begin
                    case (reg_idx)
                        `DMAAG_R_CTRL: ctrl <= pwdata[15:0] & `DMAAG_CTRL_MSK;
                        `DMAAG_R_STA:  sta  <= pwdata[10:0]; // RULE_09
                        `DMAAG_R_STB:  stb  <= pwdata[10:0]; // RULE_09
                        default:       cnt  <= pwdata[9:0];
                    endcase
                end
            end

            // Readback view tracks the latest offset used per buffer
            always @(posedge mclk) begin
                if (reset) begin
                    show_a <= 11'h000;
                    show_b <= 11'h000;
                end else begin
                    if (hit && reg_idx == `DMAAG_R_STA) begin
                        show_a <= pwdata[10:0];
                    end else if (grant[i] && !use_b) begin
                        show_a <= ofs_now; // RULE_08
                    end
                    if (hit && reg_idx == `DMAAG_R_STB) begin
                        show_b <= pwdata[10:0];
                    end else if (grant[i] && use_b) begin
                        show_b <= ofs_now; // RULE_08
                    end
                end
            end

            // Request capture; a new request beats the grant that clears
            always @(posedge mclk) begin
                if (reset || !en) begin
                    pend_r <= 1'b0;
                end else if (req_rise[i]) begin
                    pend_r <= 1'b1;
                end else if (grant[i]) begin
                    pend_r <= 1'b0;
                end
            end

            // Running address and element count
            always @(posedge mclk) begin
                if (reset || !en) begin
                    run_addr <= 11'h000;
                    served   <= 10'h000;
                    active   <= 1'b0;
                end else if (grant[i]) begin
                    run_addr <= next_run; // RULE_04
                    if (last) begin
                        served <= 10'h000; // RULE_15
                        active <= 1'b0;
                    end else begin
                        served <= served + 10'h001;
                        active <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // RAM side: one element per granted request
    // At most one grant per cycle; the last arm is unused when idle
    always @* begin
        if (grant[0]) begin
            sel_ofs = use_ofs[10:0];
        end else if (grant[1]) begin
            sel_ofs = use_ofs[21:11];
        end else begin
            sel_ofs = use_ofs[32:22];
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            ram_addr    <= `DMAAG_RAM_BASE;
            ram_strobe  <= 1'b0;
            ram_write   <= 1'b0;
            ram_byte    <= 1'b0;
            ram_channel <= 2'h0;
        end else begin
            ram_strobe <= |grant;
            if (|grant) begin
                ram_addr <= `DMAAG_RAM_BASE + {5'h00, sel_ofs}; // RULE_16
                if (grant[0]) begin
                    ram_channel <= 2'h0;
                    ram_byte    <= ch_byte[0];
                    ram_write   <= ~ch_dir[0];
                end else if (grant[1]) begin
                    ram_channel <= 2'h1;
                    ram_byte    <= ch_byte[1];
                    ram_write   <= ~ch_dir[1];
                end else begin
                    ram_channel <= 2'h2;
                    ram_byte    <= ch_byte[2];
                    ram_write   <= ~ch_dir[2];
                end
            end
        end
    end

    // Status flags: write one to clear, a new event wins over the clear
    always @* begin
        next_flag0 = flag0;
        next_flag1 = flag1;
        if (flag0_wr) begin
            next_flag0 = flag0 & ~pwdata[15:0]; // RULE_02
        end
        if (flag1_wr) begin
            next_flag1 = flag1 & ~pwdata[15:0]; // RULE_02
        end
        if (blk_done[0]) begin
            next_flag0[`DMAAG_F_CH0] = 1'b1; // RULE_01 RULE_03
        end
        if (blk_done[1]) begin
            next_flag0[`DMAAG_F_CH1] = 1'b1; // RULE_01 RULE_03
        end
        if (blk_done[2]) begin
            next_flag1[`DMAAG_F_CH2] = 1'b1; // RULE_01 RULE_03
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            flag0 <= 16'h0000;
            flag1 <= 16'h0000;
            mask0 <= 16'h0000;
            mask1 <= 16'h0000;
            irq   <= 1'b0;
        end else begin
            flag0 <= next_flag0;
            flag1 <= next_flag1;
            if (mask0_wr) begin
                mask0 <= pwdata[15:0] & `DMAAG_FLAG0_MSK;
            end
            if (mask1_wr) begin
                mask1 <= pwdata[15:0] & `DMAAG_FLAG1_MSK;
            end
            // Built from next flags so irq follows a flag without lag
            irq <= |(next_flag0 & mask0) | |(next_flag1 & mask1);
        end
    end

    // Read mux and error for unmapped addresses
    always @* begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        if (ch_valid) begin
            next_rdata = ch_rdata[ch_idx*32 +: 32];
        end else begin
            case (paddr)
                `DMAAG_A_FLAG0: next_rdata = {16'h0000, flag0};
                `DMAAG_A_FLAG1: next_rdata = {16'h0000, flag1};
                `DMAAG_A_MASK0: next_rdata = {16'h0000, mask0};
                `DMAAG_A_MASK1: next_rdata = {16'h0000, mask1};
                default:        next_err   = 1'b1;
            endcase
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & next_err;
            if (setup && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end
endmodule // dmaag_channel

// *** test/dmaag_periph_model.sv ***
// Peripheral model: turns each fire pulse that arrives while idle into one request pulse
`timescale 1ns/100ps
module dmaag_periph_model (
    input  wire logic        mclk,
    input  wire logic [2:0]  fire,
    input  wire logic [32:0] pia,
    output logic      [2:0]  periph_req,
    output logic      [32:0] periph_addr
);
    logic [3:0] cnt [3] = '{default: 4'h0};

    // Long high and low phases so the input filter sees a clean edge
    always @(posedge mclk) begin
        for (int i = 0; i < 3; i++) begin
            if (fire[i] && cnt[i] == 4'h0) begin
                cnt[i] <= 4'hf;
            end else if (cnt[i] != 4'h0) begin
                cnt[i] <= cnt[i] - 4'h1;
            end
        end
    end

    always @* begin
        for (int i = 0; i < 3; i++) begin
            periph_req[i] = cnt[i] > 4'h7;
        end
    end

    // Held like a capture buffer, stable well past the strobe
    assign periph_addr = pia;
endmodule // dmaag_periph_model

// *** test/dmaag_monitor.sv ***
// Bus and interrupt checker bound to the address generator
`timescale 1ns/100ps
module dmaag_monitor (
    input wire        mclk,
    input wire        reset,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [2:0]  periph_req,
    input wire [32:0] periph_addr,
    input wire [15:0] ram_addr,
    input wire        ram_strobe,
    input wire        ram_write,
    input wire        ram_byte,
    input wire [1:0]  ram_channel,
    input wire        irq
);
    wire wr = psel & penable & pwrite;
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (reset);

    ready_after_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    bad_addr_a: assert property
        (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    flag0_bits_a: assert property (
        pready && !pwrite && paddr == 8'h40 |-> (prdata & ~32'h4010) == 0)
        else $error("flag0 stray bits");
    flag1_bits_a: assert property (
        pready && !pwrite && paddr == 8'h44 |-> (prdata & ~32'h0100) == 0)
        else $error("flag1 stray bits");
    ram_base_a: assert property (
        ram_strobe |-> ram_addr[15:11] == 5'h08 && ram_channel != 2'h3)
        else $error("strobe outside RAM region");
    irq_rise_a: assert property ($rose(irq) |->
        ram_strobe || $past(wr) || $past(wr, 2))
        else $error("irq rose without cause");
    irq_fall_a: assert property (
        $fell(irq) |-> $past(wr) || $past(wr, 2))
        else $error("irq fell without a write");
    reset_out_a: assert property (disable iff (1'b0)
        reset |=> ram_addr == 16'h4000 && !irq && !ram_strobe && !pready)
        else $error("outputs not at reset values");

    cover property (ram_strobe && ram_byte);
    cover property ($rose(irq));
    cover property (pslverr);
    cover property (ram_strobe && $rose(irq));
endmodule // dmaag_monitor

bind dmaag_channel dmaag_monitor mon_u (.mclk, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .periph_req,
    .periph_addr, .ram_addr, .ram_strobe, .ram_write, .ram_byte,
    .ram_channel, .irq);

// *** test/testbench.sv ***
// Register and transfer tests for the address generator
`timescale 1ns/100ps
module testbench;
    logic        mclk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [2:0]  fire;
    logic [32:0] pia;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [2:0]  periph_req;
    wire  [32:0] periph_addr;
    wire  [15:0] ram_addr;
    wire         ram_strobe;
    wire         ram_write;
    wire         ram_byte;
    wire  [1:0]  ram_channel;
    wire         irq;
    logic [31:0] rdat;
    logic        rerr;
    int          bad_count = 0;
    int          n_checks = 0;

    dmaag_channel dut_u (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .periph_req, .periph_addr,
        .ram_addr, .ram_strobe, .ram_write, .ram_byte, .ram_channel, .irq);
    dmaag_periph_model per_u (.mclk, .fire, .pia, .periph_req,
        .periph_addr);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic ap(input logic [7:0] a, input logic [31:0] d,
                      input logic w);
        int t;
        t = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) chk(32'h0, 32'h1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ap(a, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ap(a, 32'h0, 1'b0);
        chk(rdat, e);
    endtask

    // Expected: {channel, write, byte, address}
    task automatic rq(input int ch, input logic [19:0] e);
        int t;
        t = 0;
        @(posedge mclk);
        fire[ch] <= 1'b1;
        @(posedge mclk);
        fire[ch] <= 1'b0;
        do begin
            @(posedge mclk);
            t++;
        end while (ram_strobe !== 1'b1 && t < 40);
        chk({12'h0, ram_channel, ram_write, ram_byte, ram_addr}, {12'h0, e});
        repeat (10) @(posedge mclk);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        fire = 3'h0;
        pia = 33'h0;
        reset = 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h48, 32'h0);
        $display("test reset done");
        wr(8'h00, 32'h8000);
        wr(8'h04, 32'h10);
        wr(8'h0c, 32'h2);
        rq(0, 20'h24010);
        rq(0, 20'h24012);
        rd(8'h40, 32'h0);
        rq(0, 20'h24014);
        rd(8'h40, 32'h10);
        rd(8'h04, 32'h14);
        rq(0, 20'h24010);
        wr(8'h40, 32'h10);
        rd(8'h40, 32'h0);
        $display("test postinc done");
        wr(8'h10, 32'hc001);
        wr(8'h14, 32'h300);
        wr(8'h18, 32'h21);
        wr(8'h1c, 32'h1);
        rq(1, 20'h74021);
        rq(1, 20'h74022);
        rd(8'h40, 32'h4000);
        wr(8'h48, 32'h4000);
        irq_is(1'b1);
        wr(8'h48, 32'h0);
        irq_is(1'b0);
        wr(8'h48, 32'h4000);
        wr(8'h40, 32'h4000);
        irq_is(1'b0);
        rq(1, 20'h74021);
        rq(1, 20'h74022);
        irq_is(1'b1);
        wr(8'h40, 32'h4000);
        irq_is(1'b0);
        $display("test byte irq done");
        wr(8'h20, 32'ha010);
        wr(8'h24, 32'h40);
        wr(8'h2c, 32'h1);
        rq(2, 20'h84040);
        rq(2, 20'h84040);
        rd(8'h44, 32'h100);
        $display("test noinc done");
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h8000);
        wr(8'h0c, 32'h3);
        rq(0, 20'h24010);
        rq(0, 20'h24012);
        wr(8'h00, 32'h8010);
        rq(0, 20'h24014);
        rq(0, 20'h24014);
        $display("test switch done");
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h40, 32'h0);
        $display("test midreset done");
        wr(8'h10, 32'h8020);
        wr(8'h14, 32'h100);
        pia <= 33'h2800;
        rq(1, 20'h64105);
        ap(8'h50, 32'h0, 1'b0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        ap(8'h06, 32'h5, 1'b1);
        chk({31'h0, rerr}, 32'h1);
        rd(8'h04, 32'h0);
        $display("test refuse done");
        give_verdict();
    end

    // Tests need about 400 cycles
    initial begin
        #100000;
        bad_count++;
        give_verdict();
    end
endmodule // testbench
